// [hw/dmio_pkg.sv]
// package for the drive mode discrete i/o block
// assumes one 125 MHz clock and an avalon-mm register master
package dmio_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ     = 125;
  localparam int unsigned DEB_TIME_NS = 2000;  // input settle time
  localparam int unsigned DEB_CYC     = (DEB_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DEB_W       = $clog2(DEB_CYC + 1);
  localparam int unsigned BLINK_DEF   = 62_500_000;  // half period, 0.5 s
  localparam int unsigned NODE_WAIT   = 4;           // settle before strap capture

  // register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_NODE   = 6'h04;
  localparam logic [5:0] OFS_DECEL  = 6'h08;
  localparam logic [5:0] OFS_PROF   = 6'h0C;
  localparam logic [5:0] OFS_STATUS = 6'h10;

  // field positions and reset values
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_BRIDGE   = 2;
  localparam logic [15:0] DECEL_RST     = 16'h0064;
  localparam logic [7:0]  ECO_ACC_RST   = 8'h10;
  localparam logic [7:0]  ECO_PWR_RST   = 8'h80;
  localparam logic [7:0]  PERF_ACC_RST  = 8'h40;
  localparam logic [7:0]  FULL_POWER    = 8'hFF;
  localparam logic [6:0]  NODE_BASE     = 7'h01;
  localparam logic [6:0]  NODE_CFG_STRAP = 7'h00;

  // operating modes
  typedef enum logic [1:0] {
    DMIO_MODE_EV,
    DMIO_MODE_CAN,
    DMIO_MODE_SERIAL,
    DMIO_MODE_SPARE
  } dmio_mode_t;

  // discrete inputs, in debounce-bit order
  localparam int unsigned NPIN = 11;
  typedef struct packed {
    logic reverse_request;
    logic ahead_request;
    logic performance_select_input;
    logic parking_lock_input;
    logic safety_enable_input;
    logic fault_clear_input;
    logic negative_limit_input;
    logic positive_limit_input;
    logic homing_switch_input;
    logic node_select_bit1;
    logic node_select_bit0;
  } dmio_pins_t;

  // commands to motor core
  typedef struct packed {
    logic       run_fwd;
    logic       run_rev;
    logic       halt;
    logic       brake_release;
    logic       perf_profile;
    logic [7:0] accel_rate;
    logic [7:0] power_limit;
  } dmio_cmd_t;

endpackage : dmio_pkg

// [hw/dmio_top.sv]
// drive mode discrete i/o supervision: pins, alarm, lamps, node id
// assumes pins arrive asynchronously and core signals on clk
`timescale 1ns/1ps
module dmio_top #(
  parameter int unsigned BLINK_DIV = dmio_pkg::BLINK_DEF
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               arst_n,
  // avalon-mm slave
  input  wire logic [5:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // discrete pins, asynchronous
  input  wire dmio_pkg::dmio_pins_t pins,
  // motor core side
  input  wire logic               alarm_cond,
  input  wire logic               motor_running,
  input  wire logic [15:0]        velocity,
  input  wire logic               throttle_neutral,
  output dmio_pkg::dmio_cmd_t     cmd,
  output logic                    bridge_active,
  // network mode side
  output logic                    can_enable,
  output logic                    serial_enable,
  output logic [6:0]              node_id,
  output logic                    neg_limit_hit,
  output logic                    pos_limit_hit,
  output logic                    home_hit,
  // lamps and power outputs
  output logic                    status_output,
  output logic                    alarm_output,
  output logic                    decel_lamp_output,
  output logic                    brake_coil_output,
  output logic                    fan_supply_output
);

  localparam int unsigned BW = $clog2(BLINK_DIV + 1);

  // synchronise then debounce every pin
  logic [dmio_pkg::NPIN-1:0] raw, meta_r, sync_r, clean_r;
  assign raw = pins;
  genvar g;
  generate
    for (g = 0; g < dmio_pkg::NPIN; g++) begin : g_deb
      logic [dmio_pkg::DEB_W-1:0] cnt_r;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= raw[g];
          sync_r[g] <= meta_r[g];
        end
      end
      // level accepted only after it held steady for the settle time
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_r      <= '0;
          clean_r[g] <= 1'b0;
        end else if (sync_r[g] == clean_r[g]) begin
          cnt_r <= '0;
        end else if (cnt_r == dmio_pkg::DEB_W'(dmio_pkg::DEB_CYC - 1)) begin
          cnt_r      <= '0;
          clean_r[g] <= sync_r[g];
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  endgenerate

  dmio_pkg::dmio_pins_t pin;
  assign pin = clean_r;

  // register file
  logic [1:0]  mode_r;
  logic        bridge_req_r;
  logic [6:0]  node_cfg_r;
  logic [15:0] decel_thr_r;
  logic [7:0]  eco_acc_r, eco_pwr_r, perf_acc_r;
  logic        ack_r;
  logic [31:0] rdata_nxt;
  logic        alarm_r, blink_r, perf_r, park_r, decel_r;
  logic [6:0]  strap_id_r;

  dmio_pkg::dmio_mode_t mode;
  assign mode = dmio_pkg::dmio_mode_t'(mode_r);
  wire ev_mode  = (mode == dmio_pkg::DMIO_MODE_EV);
  wire can_mode = (mode == dmio_pkg::DMIO_MODE_CAN);
  wire ser_mode = (mode == dmio_pkg::DMIO_MODE_SERIAL);

  // one wait cycle for every access, answer on the second edge
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  wire wr_go = avs_write & ack_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ack_r <= 1'b0;
    else         ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (avs_address == dmio_pkg::OFS_CTRL) begin
      rdata_nxt[1:0] = mode_r;
      rdata_nxt[dmio_pkg::CTRL_BRIDGE] = bridge_req_r;
    end else if (avs_address == dmio_pkg::OFS_NODE) begin
      rdata_nxt[6:0]  = node_cfg_r;
      rdata_nxt[14:8] = node_id;
    end else if (avs_address == dmio_pkg::OFS_DECEL) begin
      rdata_nxt[15:0] = decel_thr_r;
    end else if (avs_address == dmio_pkg::OFS_PROF) begin
      rdata_nxt[23:0] = {perf_acc_r, eco_pwr_r, eco_acc_r};
    end else if (avs_address == dmio_pkg::OFS_STATUS) begin
      rdata_nxt[10:0] = clean_r;
      rdata_nxt[16]   = alarm_r;
      rdata_nxt[17]   = bridge_active;
      rdata_nxt[18]   = perf_r;
      rdata_nxt[19]   = park_r;
      rdata_nxt[20]   = decel_r;
      rdata_nxt[21]   = motor_running;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)                            avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_r)             avs_readdata <= rdata_nxt;
  end

  // register writes with byte lanes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r       <= 2'h0;
      bridge_req_r <= 1'b0;
      node_cfg_r   <= dmio_pkg::NODE_CFG_STRAP;
      decel_thr_r  <= dmio_pkg::DECEL_RST;
      eco_acc_r    <= dmio_pkg::ECO_ACC_RST;
      eco_pwr_r    <= dmio_pkg::ECO_PWR_RST;
      perf_acc_r   <= dmio_pkg::PERF_ACC_RST;
    end else if (wr_go) begin
      if (avs_address == dmio_pkg::OFS_CTRL && avs_byteenable[0]) begin
        mode_r       <= avs_writedata[dmio_pkg::CTRL_MODE_LSB +: 2];
        bridge_req_r <= avs_writedata[dmio_pkg::CTRL_BRIDGE];
      end else if (avs_address == dmio_pkg::OFS_NODE && avs_byteenable[0]) begin
        node_cfg_r <= avs_writedata[6:0];
      end else if (avs_address == dmio_pkg::OFS_DECEL) begin
        if (avs_byteenable[0]) decel_thr_r[7:0]  <= avs_writedata[7:0];
        if (avs_byteenable[1]) decel_thr_r[15:8] <= avs_writedata[15:8];
      end else if (avs_address == dmio_pkg::OFS_PROF) begin
        if (avs_byteenable[0]) eco_acc_r  <= avs_writedata[7:0];
        if (avs_byteenable[1]) eco_pwr_r  <= avs_writedata[15:8];
        if (avs_byteenable[2]) perf_acc_r <= avs_writedata[23:16];
      end
    end
  end

  // bridge on only from neutral throttle with safety present
  wire safe_ok = pin.safety_enable_input;
  wire activate = bridge_req_r & ~bridge_active & throttle_neutral & safe_ok;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)                       bridge_active <= 1'b0;
    else if (!bridge_req_r || !safe_ok) bridge_active <= 1'b0;
    else if (activate)                 bridge_active <= 1'b1;
  end

  // selections frozen while the bridge runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      perf_r <= 1'b0;
      park_r <= 1'b0;
    end else if (!bridge_active && throttle_neutral && !ser_mode) begin
      perf_r <= pin.performance_select_input;
      park_r <= pin.parking_lock_input;
    end
  end

  // direction interlock, both high means stop
  wire fwd_ok = ev_mode & pin.ahead_request & ~pin.reverse_request;
  wire rev_ok = ev_mode & pin.reverse_request & ~pin.ahead_request;

  // command bundle; safety loss overrides halt, run and brake release
  always_comb begin
    cmd.halt          = ~safe_ok | ~bridge_active;
    cmd.run_fwd       = bridge_active & safe_ok & fwd_ok;
    cmd.run_rev       = bridge_active & safe_ok & rev_ok;
    cmd.brake_release = ~safe_ok | (park_r & ~ser_mode);
    cmd.perf_profile  = perf_r;
    cmd.accel_rate    = perf_r ? perf_acc_r : eco_acc_r;
    cmd.power_limit   = perf_r ? dmio_pkg::FULL_POWER : eco_pwr_r;
  end

  // brake coil power output feeds the fan in vehicle mode
  assign fan_supply_output = ev_mode;
  assign brake_coil_output = ~ev_mode & cmd.brake_release;

  // network and serial mode pins
  assign can_enable    = can_mode;
  assign serial_enable = ser_mode;
  assign neg_limit_hit = can_mode & pin.negative_limit_input;
  assign pos_limit_hit = can_mode & pin.positive_limit_input;
  assign home_hit      = can_mode & pin.homing_switch_input;

  // straps caught once after power-up from the sync flops, before the debouncers settle
  logic [3:0] boot_cnt_r;
  logic       boot_done_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_r  <= 4'h0;
      boot_done_r <= 1'b0;
      strap_id_r  <= dmio_pkg::NODE_BASE;
    end else if (!boot_done_r) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
      if (boot_cnt_r == 4'(dmio_pkg::NODE_WAIT)) begin
        boot_done_r <= 1'b1;
        strap_id_r  <= dmio_pkg::NODE_BASE
                     + {5'h00, sync_r[1], sync_r[0]};
      end
    end
  end
  assign node_id = (node_cfg_r == dmio_pkg::NODE_CFG_STRAP)
                 ? strap_id_r : node_cfg_r;

  // alarm latch, a new alarm beats a clear in the same cycle
  logic clr_prev_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) clr_prev_r <= 1'b0;
    else         clr_prev_r <= pin.fault_clear_input;
  end
  wire clr_edge = pin.fault_clear_input & ~clr_prev_r & ~ser_mode;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)         alarm_r <= 1'b0;
    else if (alarm_cond) alarm_r <= 1'b1;
    else if (clr_edge)   alarm_r <= 1'b0;
  end

  // blink divider; half period in clock cycles
  logic [BW-1:0] blink_cnt_r;
  wire blink_tick = (blink_cnt_r == BW'(BLINK_DIV - 1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)         blink_cnt_r <= '0;
    else if (blink_tick) blink_cnt_r <= '0;
    else                 blink_cnt_r <= blink_cnt_r + 1'b1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)         blink_r <= 1'b0;
    else if (blink_tick) blink_r <= ~blink_r;
  end

  // status lamp, alarm has the last word
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)            status_output <= 1'b0;
    else if (alarm_r)       status_output <= 1'b0;
    else if (motor_running) status_output <= 1'b1;
    else                    status_output <= blink_r;
  end

  // alarm pin toggles at the blink rate while an alarm stands
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)                      alarm_output <= 1'b0;
    else if (!alarm_r)                alarm_output <= 1'b0;
    else if (blink_tick)              alarm_output <= ~alarm_output;
  end

  // decel lamp: drop from last peak velocity reaches threshold
  logic [15:0] peak_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      peak_r  <= 16'h0000;
      decel_r <= 1'b0;
    end else if (!ev_mode || velocity >= peak_r) begin
      peak_r  <= velocity;
      decel_r <= 1'b0;
    end else if ((peak_r - velocity) >= decel_thr_r) begin
      decel_r <= 1'b1;
    end
  end
  assign decel_lamp_output = decel_r & ev_mode;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rev_interlock: assert property (cmd.run_rev |-> !pin.ahead_request && ev_mode)
    else $error("reverse run while ahead requested");
  a_fwd_interlock: assert property (cmd.run_fwd |-> !pin.reverse_request && ev_mode)
    else $error("forward run while reverse requested");
  a_prof_frozen: assert property (bridge_active && $past(bridge_active) |-> $stable(perf_r))
    else $error("profile changed with bridge on");
  a_park_frozen: assert property (bridge_active && $past(bridge_active) |-> $stable(park_r))
    else $error("parking lock changed with bridge on");
  a_safety_halt: assert property (!safe_ok |-> cmd.halt && cmd.brake_release && !cmd.run_fwd
                                  && !cmd.run_rev ##1 !bridge_active)
    else $error("motion without safety enable");
  a_clear_edge: assert property (alarm_r && !alarm_cond && clr_edge |=> !alarm_r)
    else $error("alarm not cleared on edge");
  a_clear_level: assert property (alarm_r && !alarm_cond && !clr_edge |=> alarm_r)
    else $error("alarm lost without edge");
  a_status_alarm: assert property (alarm_r |=> !status_output)
    else $error("status high during alarm");
  a_status_run: assert property (!alarm_r && motor_running |=> status_output)
    else $error("status low while running");
  a_alarm_toggle: assert property (alarm_r && blink_tick ##1 alarm_r
                                   |-> alarm_output != $past(alarm_output))
    else $error("alarm output did not toggle");
  a_node_strap: assert property (boot_done_r && node_cfg_r == dmio_pkg::NODE_CFG_STRAP
                                 |-> node_id >= 7'h01 && node_id <= 7'h04)
    else $error("strapped node id out of range");
  a_eco_cap: assert property (!perf_r |-> cmd.power_limit == eco_pwr_r)
    else $error("efficient profile power not capped");
  a_bus_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");

  c_bridge_on:  cover property (activate ##1 bridge_active);
  c_alarm_clr:  cover property (alarm_r ##1 clr_edge ##1 !alarm_r);
  c_decel:      cover property (decel_lamp_output);
  c_safety_off: cover property (bridge_active ##1 !safe_ok);

endmodule : dmio_top

// [dv/dmio_core_model.sv]
// core model: motor core and power stage as seen from the supervision block
// assumes cmd and bridge_active are synchronous to clk
`timescale 1ns/1ps
module dmio_core_model (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // commands from the block
  input  wire dmio_pkg::dmio_cmd_t cmd,
  input  wire logic                bridge_active,
  input  wire logic [15:0]         vel_target,
  // core state back to the block
  output logic                     motor_running,
  output logic [15:0]              velocity
);
  // spins only with bridge on and a direction; halt always wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) motor_running <= 1'b0;
    else motor_running <= bridge_active & (cmd.run_fwd | cmd.run_rev) & ~cmd.halt;
  end
  // velocity one cycle late, like a sampled encoder
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) velocity <= 16'h0000;
    else velocity <= vel_target;
  end
endmodule : dmio_core_model

// [dv/drive_mode_io_logic_bench.sv]
// bench for the drive mode discrete i/o block, avalon-mm master and pins
// assumes the core model stands in for the motor core
`timescale 1ns/1ps
module drive_mode_io_logic_bench;
  logic                clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [5:0]          avs_address;
  logic [31:0]         avs_writedata, avs_readdata, q;
  logic [3:0]          avs_byteenable;
  dmio_pkg::dmio_pins_t pins;
  dmio_pkg::dmio_cmd_t cmd;
  logic                alarm_cond, motor_running, throttle_neutral, bridge_active;
  logic [15:0]         velocity, vel_target;
  logic                can_enable, serial_enable, neg_limit_hit, pos_limit_hit, home_hit;
  logic [6:0]          node_id;
  logic                status_output, alarm_output, decel_lamp_output;
  logic                brake_coil_output, fan_supply_output;
  int                  error_cnt, check_count, c, n;

  dmio_top #(.BLINK_DIV(8)) i_dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pins(pins), .alarm_cond(alarm_cond),
    .motor_running(motor_running), .velocity(velocity),
    .throttle_neutral(throttle_neutral), .cmd(cmd), .bridge_active(bridge_active),
    .can_enable(can_enable), .serial_enable(serial_enable), .node_id(node_id),
    .neg_limit_hit(neg_limit_hit), .pos_limit_hit(pos_limit_hit), .home_hit(home_hit),
    .status_output(status_output), .alarm_output(alarm_output),
    .decel_lamp_output(decel_lamp_output), .brake_coil_output(brake_coil_output),
    .fan_supply_output(fan_supply_output));

  dmio_core_model i_core (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .bridge_active(bridge_active),
    .vel_target(vel_target), .motor_running(motor_running), .velocity(velocity));

  // free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // one avalon access; request held until waitrequest seen low at an edge
  // waitrequest and readdata are read while settled, before the edge, so the
  // ack register update at that edge cannot race the check
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int   k;
    logic wt;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    k = 0;
    do begin
      @(negedge clk);
      wt = avs_waitrequest;
      q = avs_readdata;
      @(posedge clk);
      k++;
    end while (wt !== 1'b0 && k < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 20) begin
      error_cnt++;
      print_verdict();
    end
  endtask : bus

  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // counts level changes of status (0) or alarm (1) over 40 cycles
  task chg(input int sel, output int cnt);
    logic p, v;
    cnt = 0;
    p = sel ? alarm_output : status_output;
    repeat (40) begin
      @(posedge clk);
      v = sel ? alarm_output : status_output;
      if (v !== p) cnt++;
      p = v;
    end
  endtask : chg

  // debounce needs 2 sync flops plus the settle count, so wait past it
  task settle;
    tick(dmio_pkg::DEB_CYC + 10);
  endtask : settle

  task pulse_alarm;
    alarm_cond <= 1'b1;
    @(posedge clk);
    alarm_cond <= 1'b0;
  endtask : pulse_alarm

  // main sequence
  initial begin
    error_cnt = 0; check_count = 0;
    arst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00;
    avs_writedata = 32'h0000_0000; avs_byteenable = 4'hF; pins = '0;
    pins.node_select_bit1 = 1'b1; alarm_cond = 1'b0; throttle_neutral = 1'b1;
    vel_target = 16'h0000;
    tick(3);
    arst_n <= 1'b1;
    tick(6);
    chk(node_id, 7'h03);
    chk({cmd.halt, cmd.brake_release}, 2'b11);
    chk({fan_supply_output, brake_coil_output}, 2'b10);
    rd(dmio_pkg::OFS_NODE); chk(q[14:8], 7'h03);
    rd(dmio_pkg::OFS_DECEL); chk(q[15:0], 16'h0064);
    rd(dmio_pkg::OFS_PROF); chk(q[23:0], 24'h40_8010);
    rd(6'h14); chk(q, 32'h0000_0000);
    // bridge request refused without safety, then without neutral throttle
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0004); tick(3); chk(bridge_active, 1'b0);
    pins.safety_enable_input <= 1'b1; pins.ahead_request <= 1'b1;
    pins.performance_select_input <= 1'b1; throttle_neutral <= 1'b0;
    settle(); chk(bridge_active, 1'b0);
    throttle_neutral <= 1'b1; tick(3); chk(bridge_active, 1'b1);
    chk({cmd.run_fwd, cmd.run_rev}, 2'b10);
    chk({cmd.perf_profile, cmd.accel_rate, cmd.power_limit}, 17'h1_40FF);
    chk(cmd.brake_release, 1'b0);
    tick(3); chg(0, c); chk({status_output, c[7:0]}, 9'h100);
    // selections frozen while the bridge is on
    pins.performance_select_input <= 1'b0; pins.parking_lock_input <= 1'b1;
    settle(); chk({cmd.perf_profile, cmd.brake_release}, 2'b10);
    vel_target <= 16'h0200; tick(4);
    vel_target <= 16'h019D; tick(6); chk(decel_lamp_output, 1'b0);
    vel_target <= 16'h019C; n = 0;
    while (decel_lamp_output !== 1'b1 && n < 10) begin
      @(posedge clk);
      n++;
    end
    chk(decel_lamp_output, 1'b1);
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0000); tick(3); chk(bridge_active, 1'b0);
    chk({cmd.perf_profile, cmd.accel_rate, cmd.power_limit}, 17'h0_1080);
    chk(cmd.brake_release, 1'b1);
    chg(0, c); chk(c >= 2, 1'b1);
    // reverse alone, then both requests together
    pins.ahead_request <= 1'b0; pins.reverse_request <= 1'b1; settle();
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0004); tick(3);
    chk({cmd.run_fwd, cmd.run_rev}, 2'b01);
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0000); pins.ahead_request <= 1'b1; settle();
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0004); tick(3);
    chk({cmd.run_fwd, cmd.run_rev}, 2'b00);
    pins.safety_enable_input <= 1'b0; settle();
    chk({cmd.halt, cmd.brake_release, bridge_active}, 3'b110);
    pins.safety_enable_input <= 1'b1; settle();
    // alarm set, cleared by edge only, not by a held level
    pulse_alarm(); tick(3); chk(status_output, 1'b0);
    chg(1, c); chk(c >= 2, 1'b1);
    pins.fault_clear_input <= 1'b1; settle();
    rd(dmio_pkg::OFS_STATUS); chk({q[16], alarm_output}, 2'b00);
    pulse_alarm(); settle(); rd(dmio_pkg::OFS_STATUS); chk(q[16], 1'b1);
    pins.fault_clear_input <= 1'b0; settle();
    pins.fault_clear_input <= 1'b1; settle();
    rd(dmio_pkg::OFS_STATUS); chk(q[16], 1'b0);
    // serial mode ignores the clear edge
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0002); tick(2); chk(serial_enable, 1'b1);
    pulse_alarm(); pins.fault_clear_input <= 1'b0; settle();
    pins.fault_clear_input <= 1'b1; settle();
    rd(dmio_pkg::OFS_STATUS); chk(q[16], 1'b1);
    // network mode switches, lamp gated off outside vehicle mode
    pins.negative_limit_input <= 1'b1; pins.positive_limit_input <= 1'b1;
    pins.homing_switch_input <= 1'b1; settle();
    chk({neg_limit_hit, pos_limit_hit, home_hit}, 3'b000);
    wr(dmio_pkg::OFS_CTRL, 32'h0000_0001); tick(2);
    chk({can_enable, neg_limit_hit, pos_limit_hit, home_hit}, 4'hF);
    chk(decel_lamp_output, 1'b0);
    wr(dmio_pkg::OFS_NODE, 32'h0000_002A); tick(2); chk(node_id, 7'h2A);
    print_verdict();
  end

  // watchdog against a hang
  initial begin
    #800000;
    error_cnt++;
    print_verdict();
  end
endmodule : drive_mode_io_logic_bench
